// ===== pkg/nvm_pkg.sv
// constants, opcodes and state types of the nonvolatile program command unit
// assumes one 40 MHz system clock shared with the flash and latch macros
package nvm_pkg;

	// ==========================================================
	// debug address space
	localparam logic [31:0] DATA_PORT_ADDR = 32'h0000_4720;
	localparam logic [31:0] STATUS_ADDR = 32'h0000_4724;

	// ==========================================================
	// command opcodes, first byte written to the data port
	localparam logic [7:0] OP_ERASE_ALL = 8'h01;
	localparam logic [7:0] OP_LOAD_BYTE = 8'h02;
	localparam logic [7:0] OP_COMMIT = 8'h03;
	localparam logic [7:0] OP_LOAD_ROW = 8'h04;
	localparam logic [7:0] OP_PROGRAM_ROW = 8'h05;
	localparam logic [7:0] OP_GET_TEMP = 8'h06;

	// ==========================================================
	// flash row geometry
	localparam int ROW_CODE_BYTES = 256;
	localparam int ROW_EXTRA_BYTES = 32;
	localparam int ROW_FULL_BYTES = ROW_CODE_BYTES + ROW_EXTRA_BYTES;
	localparam int ECC_GROUP = ROW_CODE_BYTES / ROW_EXTRA_BYTES;
	localparam logic [8:0] LEN_ECC_ON = 9'h100;
	localparam logic [8:0] LEN_ECC_OFF = 9'h120;
	localparam logic [8:0] LAST_COL = 9'h11F;
	localparam int ROW_ADDR_W = 8;

	// ==========================================================
	// configuration latch layout
	localparam int CFG_BYTES = 4;
	localparam int ECC_EN_BYTE = 3;
	localparam int ECC_EN_BIT = 3;
	localparam int ECC_EN_POS = ECC_EN_BYTE * 8 + ECC_EN_BIT;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;

	// ==========================================================
	// status register bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_OK = 1;
	localparam int ST_OVERTIME = 2;
	localparam int ST_REJECT = 3;
	localparam int ST_PROG = 4;

	// ==========================================================
	// flash macro operations
	localparam logic [1:0] FL_OP_NONE = 2'h0;
	localparam logic [1:0] FL_OP_ERASE = 2'h1;
	localparam logic [1:0] FL_OP_WRITE = 2'h2;

	// ==========================================================
	// timing
	localparam int CLK_HZ = 40000000;
	localparam int OVERTIME_MS = 1000;
	localparam int OVERTIME_CYCLES = OVERTIME_MS * (CLK_HZ / 1000);
	localparam int TIMER_W = 26;

	typedef enum logic [1:0] {P_IDLE, P_ARG1, P_ARG2, P_ROW} parse_t;
	typedef enum logic [1:0] {E_IDLE, E_ERASE, E_COMMIT, E_PROG} exec_t;

endpackage

// ===== pkg/row_latch_if.sv
// signals between the command unit and its double-banked row latch
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface row_latch_if;
	logic wr_en;
	logic [8:0] wr_idx;
	logic [7:0] wr_data;
	logic swap;
	logic ecc_on;
	logic [8:0] rd_idx;
	logic [7:0] rd_data;

	modport ctrl (output wr_en, wr_idx, wr_data, swap, ecc_on, rd_idx,
		input rd_data);
	modport latch (input wr_en, wr_idx, wr_data, swap, ecc_on, rd_idx,
		output rd_data);
endinterface

// ===== src/row_latch.sv
// row latch with a load bank and a program bank, plus check byte generator
// assumes the controller never writes in the cycle it swaps the banks
`timescale 1ns/1ps
module row_latch (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// controller side
	row_latch_if.latch lat
);
	import nvm_pkg::*;

	typedef struct packed {
		logic [1:0][ROW_FULL_BYTES-1:0][7:0] bank;
		logic sel;
	} latch_state_t;

	latch_state_t q;
	latch_state_t d;
	logic [ROW_FULL_BYTES-1:0][7:0] prog;
	logic [ROW_EXTRA_BYTES-1:0][7:0] ecc;

	function automatic logic [7:0] fold(input logic [ECC_GROUP-1:0][7:0] b);
		logic [7:0] x;
		x = 8'h00;
		for (int i = 0; i < ECC_GROUP; i++) begin
			x = x ^ b[i];
		end
		return x;
	endfunction

	// ==========================================================
	// bank handling: load one bank while the other is programmed
	always_comb begin
		d = q;
		if (lat.wr_en) begin
			d.bank[q.sel][lat.wr_idx] = lat.wr_data; // see [RL15]
		end
		if (lat.swap) begin
			d.sel = ~q.sel; // see [RL17]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign prog = q.bank[~q.sel];

	// ==========================================================
	// one check byte per group of eight code bytes
	for (genvar g = 0; g < ROW_EXTRA_BYTES; g++) begin : g_ecc
		assign ecc[g] = fold(prog[g*ECC_GROUP +: ECC_GROUP]); // see [RL12]
	end

	// extra bytes come from the generator when check bytes are on
	assign lat.rd_data = (lat.ecc_on && lat.rd_idx[8]) ?
		ecc[lat.rd_idx[4:0]] : prog[lat.rd_idx]; // see [RL10]

endmodule // row_latch

// ===== src/nvm_program_command_unit.sv
// command and status engine for flash and configuration latch programming
// assumes flash and latch macros on the same clock, done strobes one cycle
//
// How it works
// [RL1] bulk erase clears data, config bytes, protection; the unit only erases the flash and leaves the config latch unwritten
// [RL2] commands arrive as bytes at port 4720h
// [RL3] host polls status for completion and success
// [RL4] erase and commit time out after one second
// [RL5] byte load stages one byte of four
// [RL6] host sends four byte loads then commit
// [RL7] host sets reset pin pull-up before commit
// [RL8] host commits latch only when contents change
// [RL9] new check byte setting applies after reset
// [RL10] rows hold 256 code and 32 extra bytes
// [RL11] row load takes 256 or 288 bytes
// [RL12] check bytes generated when check mode on
// [RL13] check enable is byte 3 bit 3
// [RL14] host queries temperature twice, passes it on
// [RL15] row load fills latch, program writes row
// [RL16] one array, 256 rows of code
// [RL17] row loading overlaps ongoing row program
// [RL18] commands during busy execution are rejected
`timescale 1ns/1ps
module nvm_program_command_unit #(
	parameter int OVERTIME_LIMIT = nvm_pkg::OVERTIME_CYCLES
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// debug address space access
	input wire logic [31:0] DBG_ADDR,
	input wire logic DBG_WR,
	input wire logic DBG_RD,
	input wire logic [7:0] DBG_WDATA,
	output logic [7:0] DBG_RDATA,
	// die temperature sensor, asynchronous
	input wire logic [7:0] TEMP_IN,
	// nonvolatile configuration latch macro
	input wire logic [31:0] CFG_LATCH_Q,
	input wire logic CFG_LATCH_DONE,
	output logic CFG_LATCH_WR,
	output logic [31:0] CFG_LATCH_WDATA,
	// flash array macro
	input wire logic FL_DONE,
	output logic FL_REQ,
	output logic [1:0] FL_OP,
	output logic [nvm_pkg::ROW_ADDR_W-1:0] FL_ROW,
	output logic [8:0] FL_COL,
	output logic [7:0] FL_DATA,
	output logic [7:0] FL_TEMP
);
	import nvm_pkg::*;

	localparam logic [TIMER_W-1:0] TIMER_LAST =
		TIMER_W'(OVERTIME_LIMIT - 1);

	typedef struct packed {
		parse_t ps;
		exec_t es;
		logic [7:0] op;
		logic [7:0] arg;
		logic [8:0] cnt;
		logic [CFG_BYTES-1:0][7:0] stage;
		logic ok;
		logic overtime;
		logic reject;
		logic [7:0] result;
		logic [7:0] rdata;
		logic [7:0] temp_s1;
		logic [7:0] temp_s2;
		logic cfg_taken;
		logic ecc_on;
		logic [TIMER_W-1:0] timer;
		logic cfg_wr;
		logic [31:0] cfg_wdata;
		logic fl_req;
		logic [1:0] fl_op;
		logic [ROW_ADDR_W-1:0] fl_row;
		logic [8:0] fl_col;
		logic [7:0] fl_data;
		logic [7:0] fl_temp;
		logic lat_wr;
		logic [8:0] lat_idx;
		logic [7:0] lat_data;
		logic swap;
	} unit_state_t;

	unit_state_t q;
	unit_state_t d;
	logic wr_port;
	logic busy;
	logic [8:0] load_len;
	logic [7:0] status;

	row_latch_if lat ();

	row_latch u_row_latch (
		.clk(CLK),
		.rst(RST),
		.lat(lat.latch)
	);

	// ==========================================================
	// row latch connections
	assign lat.wr_en = q.lat_wr;
	assign lat.wr_idx = q.lat_idx;
	assign lat.wr_data = q.lat_data;
	assign lat.swap = q.swap;
	assign lat.ecc_on = q.ecc_on;
	assign lat.rd_idx = q.fl_col;

	// ==========================================================
	// decode and status view
	assign wr_port = DBG_WR && (DBG_ADDR == DATA_PORT_ADDR); // see [RL2]
	assign busy = (q.es != E_IDLE);
	assign load_len = q.ecc_on ? LEN_ECC_ON : LEN_ECC_OFF; // see [RL11]
	always_comb begin
		status = 8'h00;
		status[ST_BUSY] = busy; // see [RL3]
		status[ST_OK] = q.ok;
		status[ST_OVERTIME] = q.overtime;
		status[ST_REJECT] = q.reject;
		status[ST_PROG] = (q.es == E_PROG);
	end

	// ==========================================================
	// next state: parser first, executor after so its sets win
	always_comb begin
		d = q;
		d.lat_wr = 1'b0;
		d.swap = 1'b0;
		d.temp_s1 = TEMP_IN;
		d.temp_s2 = q.temp_s1;

		// active check mode is caught once after reset only
		if (!q.cfg_taken) begin
			d.cfg_taken = 1'b1;
			d.ecc_on = CFG_LATCH_Q[ECC_EN_POS]; // see [RL9] [RL13]
		end

		// register reads through the debug space
		if (DBG_RD) begin
			if (DBG_ADDR == DATA_PORT_ADDR) begin
				d.rdata = q.result;
			end else if (DBG_ADDR == STATUS_ADDR) begin
				d.rdata = status; // see [RL3]
			end else begin
				d.rdata = 8'h00;
			end
		end

		if (wr_port && q.cfg_taken) begin
			unique case (q.ps)
				P_IDLE: begin
					d.op = DBG_WDATA;
					if (busy && DBG_WDATA != OP_LOAD_ROW) begin
						d.reject = 1'b1; // see [RL18]
					end else begin
						if (DBG_WDATA != OP_LOAD_ROW) begin
							d.ok = 1'b0;
							d.overtime = 1'b0;
							d.reject = 1'b0;
						end
						if (DBG_WDATA == OP_ERASE_ALL) begin
							// macro wipes code, extra bytes and protection rows
							d.es = E_ERASE; // see [RL1]
							d.fl_req = 1'b1;
							d.fl_op = FL_OP_ERASE;
							d.timer = '0;
						end else if (DBG_WDATA == OP_COMMIT) begin
							d.es = E_COMMIT; // see [RL6]
							d.cfg_wr = 1'b1;
							d.cfg_wdata = q.stage;
							d.timer = '0;
						end else if (DBG_WDATA == OP_GET_TEMP) begin
							d.result = q.temp_s2; // see [RL14]
							d.ok = 1'b1;
						end else if (DBG_WDATA == OP_LOAD_ROW) begin
							d.ps = P_ROW;
							d.cnt = 9'h000;
						end else if (DBG_WDATA == OP_LOAD_BYTE ||
							DBG_WDATA == OP_PROGRAM_ROW) begin
							d.ps = P_ARG1;
						end else begin
							d.reject = 1'b1;
						end
					end
				end
				P_ARG1: begin
					d.arg = DBG_WDATA;
					d.ps = P_ARG2;
				end
				P_ARG2: begin
					d.ps = P_IDLE;
					if (q.op == OP_LOAD_BYTE) begin
						d.stage[q.arg[1:0]] = DBG_WDATA; // see [RL5]
						d.ok = 1'b1;
					end else if (busy) begin
						d.reject = 1'b1; // see [RL18]
					end else begin
						// swapping frees the load bank for the next row
						d.es = E_PROG; // see [RL15] [RL17]
						d.swap = 1'b1;
						d.fl_row = q.arg; // see [RL16]
						d.fl_temp = DBG_WDATA; // see [RL14]
						d.fl_col = 9'h000;
						d.fl_op = FL_OP_WRITE;
					end
				end
				P_ROW: begin
					d.lat_wr = 1'b1; // see [RL15]
					d.lat_idx = q.cnt;
					d.lat_data = DBG_WDATA;
					d.cnt = q.cnt + 9'h001;
					if (q.cnt == load_len - 9'h001) begin
						d.ps = P_IDLE; // see [RL11]
						d.ok = 1'b1;
					end
				end
			endcase
		end

		// executor
		unique case (q.es)
			E_IDLE: begin
			end
			E_ERASE: begin
				d.timer = q.timer + 1'b1;
				if (FL_DONE) begin
					d.fl_req = 1'b0;
					d.fl_op = FL_OP_NONE;
					d.es = E_IDLE;
					d.ok = 1'b1;
				end else if (q.timer == TIMER_LAST) begin
					d.fl_req = 1'b0; // see [RL4]
					d.fl_op = FL_OP_NONE;
					d.es = E_IDLE;
					d.overtime = 1'b1;
				end
			end
			E_COMMIT: begin
				d.timer = q.timer + 1'b1;
				if (CFG_LATCH_DONE) begin
					d.cfg_wr = 1'b0;
					d.es = E_IDLE;
					d.ok = 1'b1;
				end else if (q.timer == TIMER_LAST) begin
					d.cfg_wr = 1'b0; // see [RL4]
					d.es = E_IDLE;
					d.overtime = 1'b1;
				end
			end
			E_PROG: begin
				// one idle cycle per byte so the latch read settles
				if (!q.fl_req && !q.swap) begin
					d.fl_data = lat.rd_data; // see [RL12]
					d.fl_req = 1'b1;
				end else if (q.fl_req && FL_DONE) begin
					d.fl_req = 1'b0;
					if (q.fl_col == LAST_COL) begin
						d.es = E_IDLE; // see [RL10]
						d.fl_op = FL_OP_NONE;
						d.ok = 1'b1;
					end else begin
						d.fl_col = q.fl_col + 9'h001;
					end
				end
			end
		endcase
	end

	// ==========================================================
	// single state register
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			q <= '0;
			q.ps <= P_IDLE;
			q.es <= E_IDLE;
			q.stage <= CFG_RESET;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs straight from the state register
	assign DBG_RDATA = q.rdata;
	assign CFG_LATCH_WR = q.cfg_wr;
	assign CFG_LATCH_WDATA = q.cfg_wdata;
	assign FL_REQ = q.fl_req;
	assign FL_OP = q.fl_op;
	assign FL_ROW = q.fl_row;
	assign FL_COL = q.fl_col;
	assign FL_DATA = q.fl_data;
	assign FL_TEMP = q.fl_temp;

endmodule // nvm_program_command_unit

// ===== tb/nvm_cmd_monitor.sv
// port assertions for the nvm program command unit
// assumes a bind to the unit that passes its timeout parameter on
`timescale 1ns/1ps
module nvm_cmd_monitor #(
	parameter int OVERTIME_LIMIT = 50
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// debug space
	input wire logic [31:0] DBG_ADDR,
	input wire logic DBG_RD,
	input wire logic [7:0] DBG_RDATA,
	// macro handshakes
	input wire logic CFG_LATCH_DONE,
	input wire logic CFG_LATCH_WR,
	input wire logic [31:0] CFG_LATCH_WDATA,
	input wire logic FL_DONE,
	input wire logic FL_REQ,
	input wire logic [1:0] FL_OP,
	input wire logic [8:0] FL_COL,
	input wire logic [7:0] FL_DATA
);
	import nvm_pkg::*;
	int fl_n, nv_n;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	// =========================================
	// wait counters, too long a wait is overtime
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			fl_n <= 0;
			nv_n <= 0;
		end else begin
			fl_n <= (FL_REQ && !FL_DONE) ? fl_n + 1 : 0;
			nv_n <= (CFG_LATCH_WR && !CFG_LATCH_DONE) ? nv_n + 1 : 0;
		end
	end
	// =========================================
	// handshakes, limits and read data
	a_fl_drop: assert property (FL_REQ && FL_DONE |=> !FL_REQ)
		else $error("flash request after done");
	a_nv_drop: assert property (CFG_LATCH_WR && CFG_LATCH_DONE
		|=> !CFG_LATCH_WR)
		else $error("latch write after done");
	a_fl_limit: assert property (fl_n <= OVERTIME_LIMIT + 1)
		else $error("flash wait past limit");
	a_nv_limit: assert property (nv_n <= OVERTIME_LIMIT + 1)
		else $error("latch wait past limit");
	a_req_hold: assert property (FL_REQ && !FL_DONE &&
		fl_n < OVERTIME_LIMIT - 2 |=> FL_REQ && $stable(FL_OP) &&
		$stable(FL_COL) && $stable(FL_DATA))
		else $error("flash request changed while waiting");
	a_op_valid: assert property (FL_REQ |-> FL_OP != FL_OP_NONE)
		else $error("flash request without operation");
	a_col_range: assert property (FL_REQ &&
		FL_OP == FL_OP_WRITE |-> FL_COL <= LAST_COL)
		else $error("column beyond row");
	a_stage_hold: assert property (CFG_LATCH_WR &&
		$past(CFG_LATCH_WR) |-> $stable(CFG_LATCH_WDATA))
		else $error("staged bytes moved during commit");
	a_unmapped_rd: assert property (DBG_RD &&
		DBG_ADDR != DATA_PORT_ADDR && DBG_ADDR != STATUS_ADDR
		|=> DBG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!DBG_RD |=>
		$stable(DBG_RDATA))
		else $error("read data moved without read");
	c_erase: cover property (FL_DONE && FL_OP == FL_OP_ERASE);
	c_commit: cover property (CFG_LATCH_DONE && CFG_LATCH_WR);
	c_last: cover property (FL_DONE && FL_COL == LAST_COL);
endmodule // nvm_cmd_monitor

bind nvm_program_command_unit nvm_cmd_monitor #(
	.OVERTIME_LIMIT(OVERTIME_LIMIT)
) mon (
	.CLK(CLK), .RST(RST), .DBG_ADDR(DBG_ADDR), .DBG_RD(DBG_RD),
	.DBG_RDATA(DBG_RDATA), .CFG_LATCH_DONE(CFG_LATCH_DONE),
	.CFG_LATCH_WR(CFG_LATCH_WR), .CFG_LATCH_WDATA(CFG_LATCH_WDATA),
	.FL_DONE(FL_DONE), .FL_REQ(FL_REQ), .FL_OP(FL_OP),
	.FL_COL(FL_COL), .FL_DATA(FL_DATA)
);

// ===== tb/nvm_macro_model.sv
// behavioural flash array and configuration latch macros
// assumes the unit's clock; hang stalls every answer
`timescale 1ns/1ps
module nvm_macro_model (
	// clock, reset, stall
	input wire logic clk,
	input wire logic rst,
	input wire logic hang,
	// flash side
	input wire logic fl_req,
	input wire logic [1:0] fl_op,
	input wire logic [7:0] fl_row,
	input wire logic [8:0] fl_col,
	input wire logic [7:0] fl_data,
	input wire logic [7:0] fl_temp,
	output logic fl_done,
	// latch side
	input wire logic cfg_wr,
	input wire logic [31:0] cfg_wdata,
	output logic cfg_done,
	output logic [31:0] cfg_q
);
	import nvm_pkg::*;
	logic [7:0] mem [0:ROW_FULL_BYTES-1];
	logic [7:0] row_seen, temp_seen;
	logic erased;
	logic [1:0] fw;
	// latch contents survive reset, so only time zero sets them
	initial cfg_q = CFG_RESET;
	// =========================================
	// answers: even columns at once, odd ones late
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			fl_done <= 1'b0;
			cfg_done <= 1'b0;
			fw <= 2'h0;
			erased <= 1'b0;
		end else begin
			fw <= (fl_req && !fl_done && !hang) ? fw + 2'h1 : 2'h0;
			fl_done <= fl_req && !fl_done && !hang &&
				fw == {fl_col[0], 1'b0};
			cfg_done <= cfg_wr && !cfg_done && !hang;
			if (fl_done && fl_op == FL_OP_ERASE)
				erased <= 1'b1;
			if (fl_done && fl_op == FL_OP_WRITE) begin
				mem[fl_col] <= fl_data;
				row_seen <= fl_row;
				temp_seen <= fl_temp;
			end
			if (cfg_done)
				cfg_q <= cfg_wdata;
		end
	end
endmodule // nvm_macro_model

// ===== tb/nvm_program_command_unit_tb_top.sv
// self-checking bench for the nvm program command unit
// assumes the macro model and the bound checker are compiled alongside
`timescale 1ns/1ps
module nvm_program_command_unit_tb_top;
	import nvm_pkg::*;
	logic clk, rst, dwr, drd, hang, nwr, ndone, fdone, freq;
	logic [31:0] addr, nq, nwd;
	logic [7:0] wdata, rdata, temp, frow, fdata, ftemp, v;
	logic [1:0] fop;
	logic [8:0] fcol;
	int fail_count, cmp_count;
	// =========================================
	// clock and instances
	always #12.5 clk = ~clk;
	nvm_program_command_unit #(.OVERTIME_LIMIT(50)) DUT (
		.CLK(clk), .RST(rst), .DBG_ADDR(addr), .DBG_WR(dwr),
		.DBG_RD(drd), .DBG_WDATA(wdata), .DBG_RDATA(rdata),
		.TEMP_IN(temp), .CFG_LATCH_Q(nq), .CFG_LATCH_DONE(ndone),
		.CFG_LATCH_WR(nwr), .CFG_LATCH_WDATA(nwd), .FL_DONE(fdone),
		.FL_REQ(freq), .FL_OP(fop),
		.FL_ROW(frow), .FL_COL(fcol), .FL_DATA(fdata), .FL_TEMP(ftemp));
	nvm_macro_model macro (
		.clk(clk), .rst(rst), .hang(hang), .fl_req(freq), .fl_op(fop),
		.fl_row(frow), .fl_col(fcol), .fl_data(fdata), .fl_temp(ftemp),
		.fl_done(fdone), .cfg_wr(nwr), .cfg_wdata(nwd),
		.cfg_done(ndone), .cfg_q(nq));
	// =========================================
	// shared helpers
	task automatic complete_run();
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] pat(input int k);
		return 8'(k * 5 + 1);
	endfunction
	// one write, then a quiet cycle so the strobe never doubles up
	task automatic put(input logic [7:0] b);
		@(negedge clk);
		addr = DATA_PORT_ADDR;
		wdata = b;
		dwr = 1'b1;
		@(negedge clk);
		dwr = 1'b0;
	endtask
	task automatic get(input logic [31:0] a);
		@(negedge clk);
		addr = a;
		drd = 1'b1;
		@(negedge clk);
		drd = 1'b0;
		v = rdata;
	endtask
	task automatic idle_is(input logic [7:0] exp);
		v = 8'h01;
		for (int i = 0; i < 3000 && v[ST_BUSY] !== 1'b0; i++)
			get(STATUS_ADDR);
		chk(v, exp);
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	// =========================================
	// scenarios
	task automatic t_erase();
		put(OP_ERASE_ALL);
		idle_is(8'h02);
		chk(macro.erased, 1'b1);
	endtask
	// stalled macros: busy refusal, then overtime on erase and commit
	task automatic t_stall();
		hang = 1'b1;
		put(OP_ERASE_ALL);
		put(OP_GET_TEMP);
		get(STATUS_ADDR);
		chk(v, 8'h09);
		idle_is(8'h0C);
		put(OP_COMMIT);
		idle_is(8'h04);
		chk(nq, CFG_RESET);
		hang = 1'b0;
	endtask
	task automatic t_temp();
		put(OP_GET_TEMP);
		get(DATA_PORT_ADDR);
		chk(v, 8'h3C);
		idle_is(8'h02);
		get(32'h0000_4728);
		chk(v, 8'h00);
	endtask
	// bytes staged out of order, then committed
	// the word leaves the shared pin a plain gpio, so no pull-up step
	task automatic t_commit();
		for (int i = 3; i >= 0; i--) begin
			put(OP_LOAD_BYTE);
			put(8'(i));
			put(8'(32'h18A5_C33C >> (8 * i)));
		end
		// latch wear is high, so only a changed word is committed
		if (nq !== 32'h18A5_C33C)
			put(OP_COMMIT);
		chk(nwd, 32'h18A5_C33C);
		idle_is(8'h02);
		chk(nq, 32'h18A5_C33C);
	endtask
	task automatic t_row(input bit ecc);
		logic [7:0] x;
		int n;
		n = ecc ? ROW_CODE_BYTES : ROW_FULL_BYTES;
		put(OP_LOAD_ROW);
		for (int k = 0; k < n; k++)
			put(pat(k));
		put(OP_PROGRAM_ROW);
		put(8'hA7);
		put(8'h3C);
		// next row fills the free bank while this one programs
		put(OP_LOAD_ROW);
		for (int k = 0; k < n; k++)
			put(~pat(k));
		get(STATUS_ADDR);
		chk(v, 8'h13);
		idle_is(8'h02);
		chk(macro.row_seen, 8'hA7);
		chk(macro.temp_seen, 8'h3C);
		for (int k = 0; k < ROW_FULL_BYTES; k++) begin
			x = pat(k);
			if (ecc && k >= ROW_CODE_BYTES) begin
				x = 8'h00;
				for (int j = 0; j < ECC_GROUP; j++)
					x ^= pat((k - ROW_CODE_BYTES) * ECC_GROUP + j);
			end
			chk(macro.mem[k], x);
		end
	endtask
	// =========================================
	// main sequence and watchdog
	initial begin
		clk = 1'b0;
		{dwr, drd, hang} = 3'h0;
		addr = 32'h0000_0000;
		wdata = 8'h00;
		temp = 8'h3C;
		do_reset();
		t_erase();
		t_stall();
		t_temp();
		t_row(nq[ECC_EN_POS]);
		t_commit();
		do_reset();
		t_row(nq[ECC_EN_POS]);
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		complete_run();
	end
endmodule // nvm_program_command_unit_tb_top
